// ---- src/isq_pkg.sv ----
package isq_pkg;
  // ==================================================
  // sizes
  localparam int ISQ_NLVL = 16;
  localparam int ISQ_NSRC = 23;
  localparam int ISQ_LW   = 5;
  localparam int ISQ_AW   = 8;
  localparam int ISQ_CW   = 10;
  localparam int ISQ_FW   = 8;
  localparam int ISQ_NREG = 5;
  typedef logic [ISQ_LW-1:0] isq_lvl_t;
  // ==================================================
  // vectors and stacking
  localparam logic [15:0] ISQ_VEC_SWI   = 16'hfffc;
  localparam logic [15:0] ISQ_HW_PC_ADJ = 16'h0001;
  localparam isq_lvl_t    ISQ_LVL_SWI   = 5'h00;
  localparam int          ISQ_CCR_IBIT  = 3;
  localparam logic [2:0]  ISQ_SL_PCL    = 3'h0;
  localparam logic [2:0]  ISQ_SL_PCH    = 3'h1;
  localparam logic [2:0]  ISQ_SL_X      = 3'h2;
  localparam logic [2:0]  ISQ_SL_A      = 3'h3;
  localparam logic [2:0]  ISQ_SL_CCR    = 3'h4;
  // ==================================================
  // register map
  localparam logic [ISQ_AW-1:0] ISQ_A_CTRL  = 8'h00;
  localparam logic [ISQ_AW-1:0] ISQ_A_FLAGS = 8'h04;
  localparam logic [ISQ_AW-1:0] ISQ_A_PEND  = 8'h08;
  localparam logic [ISQ_AW-1:0] ISQ_A_BRK   = 8'h0c;
  localparam logic [ISQ_AW-1:0] ISQ_A_STAT  = 8'h10;
  localparam int ISQ_R_CTRL = 0;
  localparam int ISQ_R_FLAGS = 1;
  localparam int ISQ_R_PEND = 2;
  localparam int ISQ_R_BRK = 3;
  localparam int ISQ_R_STAT = 4;
  localparam logic [1:0] ISQ_RESP_OKAY   = 2'h0;
  localparam logic [1:0] ISQ_RESP_SLVERR = 2'h2;
  // control fields; both masks set out of reset
  localparam int ISQ_C_EXT_MASK = 0;
  localparam int ISQ_C_CLK_IE   = 1;
  localparam int ISQ_C_CLK_MON  = 2;
  localparam int ISQ_C_TMR_LO   = 3;
  localparam int ISQ_C_TMR_HI   = 8;
  localparam int ISQ_C_KEY_MASK = 9;
  localparam logic [ISQ_CW-1:0] ISQ_CTRL_RST = 10'h201;
  // sticky flag fields
  localparam int ISQ_F_EXT = 0;
  localparam int ISQ_F_CLK = 1;
  localparam int ISQ_F_TMR_LO = 2;
  localparam int ISQ_F_TMR_HI = 7;
  localparam int ISQ_BRK_EN = 16;
  // peripheral flag and enable fields
  localparam int ISQ_SPI_RX  = 0;
  localparam int ISQ_SPI_OVR = 1;
  localparam int ISQ_SPI_MOD = 2;
  localparam int ISQ_SPI_TX  = 3;
  localparam int ISQ_SPE_RX  = 0;
  localparam int ISQ_SPE_ERR = 1;
  localparam int ISQ_SPE_TX  = 2;
  localparam int ISQ_PB_SPI_RX = 8;
  // service level of each source, source 0 in the low bits
  localparam logic [ISQ_NSRC*ISQ_LW-1:0] ISQ_SRC_LVL = {
    5'h10, 5'h0f, 5'h0e, 5'h0d, 5'h0d, 5'h0c, 5'h0c, 5'h0b, 5'h0b, 5'h0b, 5'h0b, 5'h0a,
    5'h09, 5'h09, 5'h09, 5'h08, 5'h07, 5'h06, 5'h05, 5'h04, 5'h03, 5'h02, 5'h01};
  typedef enum logic [2:0] {
    ISQ_IDLE = 3'h0,
    ISQ_PUSH = 3'h1,
    ISQ_VECT = 3'h3,
    ISQ_POP  = 3'h2,
    ISQ_RSTR = 3'h6
  } isq_state_t;

  function automatic logic [ISQ_NSRC-1:0] isq_lvl_mask(input int lvl);
    logic [ISQ_NSRC-1:0] m;
    m = '0;
    for (int s = 0; s < ISQ_NSRC; s++) begin
      m[s] = (ISQ_SRC_LVL[s*ISQ_LW +: ISQ_LW] == isq_lvl_t'(lvl));
    end
    return m;
  endfunction

  function automatic logic [15:0] isq_vector(input isq_lvl_t l);
    return ISQ_VEC_SWI - {10'h000, l, 1'b0};
  endfunction

  function automatic logic [31:0] isq_strb_mask(input logic [3:0] strb);
    return {{8{strb[3]}}, {8{strb[2]}}, {8{strb[1]}}, {8{strb[0]}}};
  endfunction

  function automatic logic [ISQ_NREG-1:0] isq_reg_sel(input logic [ISQ_AW-1:0] a);
    return {a == ISQ_A_STAT, a == ISQ_A_BRK, a == ISQ_A_PEND, a == ISQ_A_FLAGS, a == ISQ_A_CTRL};
  endfunction
endpackage

// ---- src/isq_prio_enc.sv ----
`timescale 1ns/1ps
module isq_prio_enc
  import isq_pkg::*;
#(
  parameter int NLVL = ISQ_NLVL
) (
  // requests, bit 0 is level 1
  input  wire logic [NLVL-1:0] req,
  // winner
  output logic                 any,
  output isq_lvl_t             lvl
);
  assign any = |req;

  always_comb begin
    lvl = ISQ_LVL_SWI;
    for (int i = NLVL - 1; i >= 0; i--) begin
      if (req[i]) begin
        lvl = isq_lvl_t'(i + 1);
      end
    end
  end
endmodule

// ---- src/isq_sequencer.sv ----
// Function
// - enter only at an instruction boundary
// - stack context, upper index byte excluded
// - return instruction unstacks the context
// - entry sets the global mask bit
// - latched service is never pre-empted
// - load pc from the level's vector
// - maskable requests checked only when unmasked
// - lowest level number served first
// - pending request taken right after return
// - software trap is non-maskable, level 0
// - hardware stacks pc-1, trap stacks pc
// - mask gates all but software trap
// - break address forces a software trap
// - low pin latches level 1 request
// - monitored clock loss sets level 2 flag
// - timer wrap sets rollover flag
// - channel event sets channel flag
// - readable pending bit per level 1-16
//
// The AXI4-Lite interface to the registers and the register offsets are this design's own decisions.
`timescale 1ns/1ps
module isq_sequencer
  import isq_pkg::*;
(
  // clock and reset
  input  wire logic                    sys_clk,
  input  wire logic                    rst,
  // axi4-lite slave
  input  wire logic [isq_pkg::ISQ_AW-1:0] awaddr,
  input  wire logic                    awvalid,
  output logic                         awready,
  input  wire logic [31:0]             wdata,
  input  wire logic [3:0]              wstrb,
  input  wire logic                    wvalid,
  output logic                         wready,
  output logic [1:0]                   bresp,
  output logic                         bvalid,
  input  wire logic                    bready,
  input  wire logic [isq_pkg::ISQ_AW-1:0] araddr,
  input  wire logic                    arvalid,
  output logic                         arready,
  output logic [31:0]                  rdata,
  output logic [1:0]                   rresp,
  output logic                         rvalid,
  input  wire logic                    rready,
  // request sources
  input  wire logic                    ext_req_n,
  input  wire logic                    clock_lost,
  input  wire logic                    t1_wrap,
  input  wire logic                    t1_ch0_event,
  input  wire logic                    t1_ch1_event,
  input  wire logic                    t2_wrap,
  input  wire logic                    t2_ch0_event,
  input  wire logic                    t2_ch1_event,
  input  wire logic [3:0]              spi_flag,
  input  wire logic [2:0]              spi_irq_en,
  input  wire logic [7:0]              sci_flag,
  input  wire logic [7:0]              sci_irq_en,
  input  wire logic                    keypad_flag,
  input  wire logic                    conversion_done_flag,
  input  wire logic                    conversion_irq_enable,
  input  wire logic                    tick_rollover_flag,
  input  wire logic                    tick_irq_enable,
  // cpu core side
  input  wire logic                    instr_done,
  input  wire logic                    swi_instr,
  input  wire logic                    rti_instr,
  input  wire logic [15:0]             cpu_pc,
  input  wire logic [7:0]              cpu_x_lo,
  input  wire logic [7:0]              cpu_acc,
  input  wire logic [7:0]              cpu_ccr,
  input  wire logic                    fetch_valid,
  input  wire logic [15:0]             fetch_addr,
  input  wire logic [7:0]              pop_data,
  output logic                         cpu_hold,
  output logic                         push_valid,
  output logic [7:0]                   push_data,
  output logic                         pop_req,
  output logic                         set_imask,
  output logic                         vector_valid,
  output logic [15:0]                  vector_addr,
  output logic                         resume_valid,
  output logic [15:0]                  resume_pc,
  output logic [7:0]                   resume_x_lo,
  output logic [7:0]                   resume_acc,
  output logic [7:0]                   resume_ccr
);
  import isq_pkg::*;

  default clocking cb @(posedge sys_clk);
  endclocking
  default disable iff (rst);

  // ==================================================
  // registers and state
  logic [ISQ_CW-1:0]    ctrl;
  logic [ISQ_FW-1:0]    flags;
  logic [ISQ_BRK_EN:0]  brk;
  logic                 brk_hit;
  isq_state_t           state;
  logic [2:0]           cnt;
  isq_lvl_t             act_lvl;
  logic                 lat_swi;
  logic [15:0]          stk_pc;
  logic [7:0]           stk_x;
  logic [7:0]           stk_a;
  logic [7:0]           stk_ccr;
  logic [ISQ_AW-1:0]    aw_q;
  logic [31:0]          wd_q;
  logic [3:0]           ws_q;

  // ==================================================
  // request combining
  wire logic [ISQ_NLVL-1:0] pend;
  wire logic                pend_any;
  isq_lvl_t                 enc_lvl;
  wire logic [3:0]          spi_en4 = {spi_irq_en[ISQ_SPE_TX], spi_irq_en[ISQ_SPE_ERR],
                                       spi_irq_en[ISQ_SPE_ERR], spi_irq_en[ISQ_SPE_RX]};
  wire logic [ISQ_NSRC-1:0] src_flag = {tick_rollover_flag, conversion_done_flag, keypad_flag,
                                        sci_flag, spi_flag, flags};
  wire logic [ISQ_NSRC-1:0] src_en = {tick_irq_enable, conversion_irq_enable, ~ctrl[ISQ_C_KEY_MASK],
                                      sci_irq_en, spi_en4, ctrl[ISQ_C_TMR_HI:ISQ_C_TMR_LO],
                                      ctrl[ISQ_C_CLK_IE], ~ctrl[ISQ_C_EXT_MASK]};

  isq_src_merge #(
    .NLVL (ISQ_NLVL),
    .NSRC (ISQ_NSRC)
  ) u_merge (
    .src_flag (src_flag),
    .src_en   (src_en),
    .pend     (pend)
  );

  isq_prio_enc #(
    .NLVL (ISQ_NLVL)
  ) u_enc (
    .req (pend),
    .any (pend_any),
    .lvl (enc_lvl)
  );

  // ==================================================
  // register bus decode
  wire logic [ISQ_NREG-1:0] wsel  = isq_reg_sel(aw_q);
  wire logic [ISQ_NREG-1:0] rsel  = isq_reg_sel(araddr);
  wire logic [31:0]         wmask = isq_strb_mask(ws_q);
  wire logic                do_wr = ~awready & ~wready & ~bvalid;
  wire logic                wr_ok = wsel[ISQ_R_CTRL] | wsel[ISQ_R_FLAGS] | wsel[ISQ_R_BRK];
  wire logic                rd_go = arvalid & arready;
  wire logic [31:0]         wr_val = wd_q & wmask;
  wire logic [31:0]         st_word = {22'h000000, cpu_hold, lat_swi, act_lvl, state};
  wire logic [31:0]         rd_mux = rsel[ISQ_R_CTRL]  ? {22'h000000, ctrl} :
                                     rsel[ISQ_R_FLAGS] ? {24'h000000, flags} :
                                     rsel[ISQ_R_PEND]  ? {15'h0000, pend, 1'b0} :
                                     rsel[ISQ_R_BRK]   ? {15'h0000, brk} :
                                     rsel[ISQ_R_STAT]  ? st_word : 32'h00000000;
  wire logic [ISQ_CW-1:0]   next_ctrl = (ctrl & ~wmask[ISQ_CW-1:0]) | wr_val[ISQ_CW-1:0];
  wire logic [ISQ_BRK_EN:0] next_brk  = (brk & ~wmask[ISQ_BRK_EN:0]) | wr_val[ISQ_BRK_EN:0];

  always_ff @(posedge sys_clk) begin
    if (rst) begin
      awready <= 1'b1;
      wready  <= 1'b1;
      bvalid  <= 1'b0;
      bresp   <= ISQ_RESP_OKAY;
      aw_q    <= '0;
      wd_q    <= '0;
      ws_q    <= '0;
    end else begin
      if (awvalid && awready) begin
        awready <= 1'b0;
        aw_q    <= awaddr;
      end
      if (wvalid && wready) begin
        wready <= 1'b0;
        wd_q   <= wdata;
        ws_q   <= wstrb;
      end
      if (do_wr) begin
        bvalid <= 1'b1;
        bresp  <= wr_ok ? ISQ_RESP_OKAY : ISQ_RESP_SLVERR;
      end
      if (bvalid && bready) begin
        bvalid  <= 1'b0;
        awready <= 1'b1;
        wready  <= 1'b1;
      end
    end
  end

  always_ff @(posedge sys_clk) begin
    if (rst) begin
      arready <= 1'b1;
      rvalid  <= 1'b0;
      rdata   <= '0;
      rresp   <= ISQ_RESP_OKAY;
    end else if (rd_go) begin
      arready <= 1'b0;
      rvalid  <= 1'b1;
      rdata   <= rd_mux;
      rresp   <= (|rsel) ? ISQ_RESP_OKAY : ISQ_RESP_SLVERR;
    end else if (rvalid && rready) begin
      rvalid  <= 1'b0;
      arready <= 1'b1;
    end
  end

  // ==================================================
  // sticky flags; a set in the clearing cycle wins
  // low pin latches
  wire logic              ext_set = ~ext_req_n;
  wire logic              clk_set = clock_lost & ctrl[ISQ_C_CLK_MON];
  wire logic [5:0]        tmr_set = {t2_wrap, t2_ch1_event, t2_ch0_event, t1_wrap, t1_ch1_event, t1_ch0_event};
  wire logic [ISQ_FW-1:0] flag_set = {tmr_set, clk_set, ext_set};
  wire logic [ISQ_FW-1:0] flag_clr = (do_wr & wsel[ISQ_R_FLAGS]) ? wr_val[ISQ_FW-1:0] : '0;
  wire logic [ISQ_FW-1:0] next_flags = (flags & ~flag_clr) | flag_set;

  wire logic brk_match = fetch_valid & brk[ISQ_BRK_EN] & (fetch_addr == brk[ISQ_BRK_EN-1:0]);

  // ==================================================
  // sequencing
  // software trap ignores the mask
  wire logic take_swi  = swi_instr | brk_hit;
  wire logic take_hw   = pend_any & ~cpu_ccr[ISQ_CCR_IBIT];
  wire logic boundary  = (state == ISQ_IDLE) & instr_done;
  wire logic swi_taken = boundary & ~rti_instr & take_swi;
  wire logic chain     = pend_any & ~resume_ccr[ISQ_CCR_IBIT];
  wire logic [15:0] hw_pc = cpu_pc - ISQ_HW_PC_ADJ;
  wire logic [2:0]  pop_slot = ISQ_SL_CCR - cnt;
  wire logic        next_brk_hit = brk_match | (brk_hit & ~swi_taken);

  isq_state_t  next_state;
  logic [2:0]  next_cnt;
  isq_lvl_t    next_lvl;
  logic        next_swi;
  logic [15:0] next_pc;
  logic [7:0]  next_x;
  logic [7:0]  next_a;
  logic [7:0]  next_ccr;

  always_comb begin
    next_state = state;
    next_cnt   = cnt;
    next_lvl   = act_lvl;
    next_swi   = lat_swi;
    next_pc    = stk_pc;
    next_x     = stk_x;
    next_a     = stk_a;
    next_ccr   = stk_ccr;
    unique case (state)
      ISQ_IDLE: begin
        if (boundary && rti_instr) begin
          next_state = ISQ_POP;
          next_cnt   = ISQ_SL_PCL;
        end else if (boundary && (take_swi || take_hw)) begin
          next_state = ISQ_PUSH;
          next_cnt   = ISQ_SL_PCL;
          next_swi   = take_swi;
          next_lvl   = take_swi ? ISQ_LVL_SWI : enc_lvl;
          next_pc    = take_swi ? cpu_pc : hw_pc;
          next_x     = cpu_x_lo;
          next_a     = cpu_acc;
          next_ccr   = cpu_ccr;
        end
      end
      // level held until the vector is out
      ISQ_PUSH: begin
        if (cnt == ISQ_SL_CCR) begin
          next_state = ISQ_VECT;
        end else begin
          next_cnt = 3'(cnt + 3'h1);
        end
      end
      ISQ_VECT: begin
        next_state = ISQ_IDLE;
      end
      ISQ_POP: begin
        if (cnt == ISQ_SL_CCR) begin
          next_state = ISQ_RSTR;
        end else begin
          next_cnt = 3'(cnt + 3'h1);
        end
      end
      ISQ_RSTR: begin
        if (chain) begin
          next_state = ISQ_PUSH;
          next_cnt   = ISQ_SL_PCL;
          next_swi   = 1'b0;
          next_lvl   = enc_lvl;
          next_pc    = resume_pc;
          next_x     = resume_x_lo;
          next_a     = resume_acc;
          next_ccr   = resume_ccr;
        end else begin
          next_state = ISQ_IDLE;
        end
      end
    endcase
  end

  // push order, upper index byte never stacked
  wire logic [7:0] next_push_data = (next_cnt == ISQ_SL_PCL) ? next_pc[7:0] :
                                    (next_cnt == ISQ_SL_PCH) ? next_pc[15:8] :
                                    (next_cnt == ISQ_SL_X)   ? next_x :
                                    (next_cnt == ISQ_SL_A)   ? next_a : next_ccr;

  always_ff @(posedge sys_clk) begin
    if (rst) begin
      ctrl    <= ISQ_CTRL_RST;
      flags   <= '0;
      brk     <= '0;
      brk_hit <= 1'b0;
    end else begin
      flags   <= next_flags;
      brk_hit <= next_brk_hit;
      if (do_wr && wsel[ISQ_R_CTRL]) begin
        ctrl <= next_ctrl;
      end
      if (do_wr && wsel[ISQ_R_BRK]) begin
        brk <= next_brk;
      end
    end
  end

  always_ff @(posedge sys_clk) begin
    if (rst) begin
      state   <= ISQ_IDLE;
      cnt     <= '0;
      act_lvl <= ISQ_LVL_SWI;
      lat_swi <= 1'b0;
      stk_pc  <= '0;
      stk_x   <= '0;
      stk_a   <= '0;
      stk_ccr <= '0;
    end else begin
      state   <= next_state;
      cnt     <= next_cnt;
      act_lvl <= next_lvl;
      lat_swi <= next_swi;
      stk_pc  <= next_pc;
      stk_x   <= next_x;
      stk_a   <= next_a;
      stk_ccr <= next_ccr;
    end
  end

  // mask set and vector with entry
  always_ff @(posedge sys_clk) begin
    if (rst) begin
      cpu_hold     <= 1'b0;
      push_valid   <= 1'b0;
      push_data    <= '0;
      pop_req      <= 1'b0;
      set_imask    <= 1'b0;
      vector_valid <= 1'b0;
      vector_addr  <= '0;
      resume_valid <= 1'b0;
    end else begin
      cpu_hold     <= (next_state != ISQ_IDLE);
      push_valid   <= (next_state == ISQ_PUSH);
      push_data    <= next_push_data;
      pop_req      <= (next_state == ISQ_POP);
      set_imask    <= (next_state == ISQ_VECT);
      vector_valid <= (next_state == ISQ_VECT);
      vector_addr  <= isq_vector(next_lvl);
      resume_valid <= (next_state == ISQ_RSTR);
    end
  end

  always_ff @(posedge sys_clk) begin
    if (rst) begin
      resume_pc   <= '0;
      resume_x_lo <= '0;
      resume_acc  <= '0;
      resume_ccr  <= '0;
    end else if (state == ISQ_POP) begin
      if (pop_slot == ISQ_SL_CCR) resume_ccr <= pop_data;
      if (pop_slot == ISQ_SL_A) resume_acc <= pop_data;
      if (pop_slot == ISQ_SL_X) resume_x_lo <= pop_data;
      if (pop_slot == ISQ_SL_PCH) resume_pc[15:8] <= pop_data;
      if (pop_slot == ISQ_SL_PCL) resume_pc[7:0] <= pop_data;
    end
  end

  // ==================================================
  // checks
  a_boundary_only: assert property ($rose(cpu_hold) |-> $past(instr_done))
    else $error("entry away from a boundary");
  a_push_order: assert property ($rose(push_valid) |-> push_data == stk_pc[7:0] ##1 push_data == stk_pc[15:8]
    ##1 push_data == stk_x ##1 push_data == stk_a ##1 push_data == stk_ccr)
    else $error("wrong stacking order");
  a_push_five: assert property ($rose(push_valid) |-> push_valid[*5] ##1 (!push_valid && set_imask))
    else $error("push length wrong");
  a_pop_resume: assert property ($rose(pop_req) |-> pop_req[*5] ##1 (!pop_req && resume_valid))
    else $error("unstacking sequence wrong");
  a_mask_with_vec: assert property (vector_valid |-> set_imask && $past(push_valid))
    else $error("mask not set at entry");
  a_level_held: assert property ((state == ISQ_VECT || state == ISQ_PUSH) && $past(state) != ISQ_IDLE
    && $past(state) != ISQ_RSTR |-> $stable(act_lvl))
    else $error("service level changed");
  a_vector_addr: assert property (vector_valid |-> vector_addr == isq_vector(act_lvl))
    else $error("wrong vector");
  a_mask_blocks: assert property ($past(boundary && cpu_ccr[ISQ_CCR_IBIT] && !take_swi && !rti_instr)
    |-> !cpu_hold)
    else $error("masked request taken");
  a_lowest_first: assert property ($rose(cpu_hold) && !lat_swi && !$past(rti_instr)
    |-> act_lvl == $past(enc_lvl))
    else $error("not lowest level");
  a_chain_entry: assert property (resume_valid && chain |=> push_valid && !lat_swi)
    else $error("pending request not chained");
  a_trap_nmi: assert property ($past(swi_taken) |-> cpu_hold && lat_swi && act_lvl == ISQ_LVL_SWI)
    else $error("software trap not level 0");
  a_hw_pc: assert property ($rose(push_valid) && !lat_swi && !$past(resume_valid)
    |-> stk_pc == 16'($past(cpu_pc) - ISQ_HW_PC_ADJ))
    else $error("hardware entry pc wrong");
  a_trap_pc: assert property ($rose(push_valid) && lat_swi |-> stk_pc == $past(cpu_pc))
    else $error("trap pc wrong");
  a_break_hit: assert property (brk_match |=> brk_hit)
    else $error("break not caught");
  a_ext_flag: assert property (!ext_req_n |=> flags[ISQ_F_EXT])
    else $error("pin request lost");
  a_clk_flag: assert property (clock_lost && ctrl[ISQ_C_CLK_MON] |=> flags[ISQ_F_CLK])
    else $error("clock loss lost");
  a_tmr_flags: assert property (t1_wrap || t2_ch0_event |=> flags[ISQ_F_TMR_LO + 2] || flags[ISQ_F_TMR_LO + 3])
    else $error("timer flag lost");
  a_spi_merge: assert property (pend[ISQ_PB_SPI_RX] == ((spi_flag[ISQ_SPI_RX] & spi_irq_en[ISQ_SPE_RX])
    | ((spi_flag[ISQ_SPI_OVR] | spi_flag[ISQ_SPI_MOD]) & spi_irq_en[ISQ_SPE_ERR])))
    else $error("shared vector request wrong");
  c_hw_entry: cover property ($rose(push_valid) && !lat_swi);
  c_trap_entry: cover property (swi_taken ##6 vector_valid);
  c_chain: cover property (resume_valid && chain);
  c_break: cover property (brk_match ##[1:50] swi_taken);
endmodule

// ---- src/isq_src_merge.sv ----
`timescale 1ns/1ps
module isq_src_merge
  import isq_pkg::*;
#(
  parameter int NLVL = ISQ_NLVL,
  parameter int NSRC = ISQ_NSRC
) (
  // sources
  input  wire logic [NSRC-1:0] src_flag,
  input  wire logic [NSRC-1:0] src_en,
  // one bit per level, bit 0 is level 1
  output logic      [NLVL-1:0] pend
);
  wire logic [NSRC-1:0] live = src_flag & src_en;

  genvar l;
  generate
    for (l = 0; l < NLVL; l++) begin : g_lvl
      assign pend[l] = |(live & isq_lvl_mask(l + 1));
    end
  endgenerate
endmodule

// ---- test/isq_cpu_model.sv ----
`timescale 1ns/1ps
// ==========
// stack memory of the cpu core
module isq_cpu_model (
  input  wire logic       sys_clk,
  input  wire logic       push_valid,
  input  wire logic [7:0] push_data,
  input  wire logic       pop_req,
  output logic      [7:0] pop_data
);
  logic [7:0] stk [16];
  logic [3:0] sp = '0;
  // idle lines show the inverse, so a stray sample is caught
  assign pop_data = pop_req ? stk[sp - 4'h1] : ~stk[sp - 4'h1];
  always @(posedge sys_clk) begin
    if (push_valid) begin
      stk[sp] <= push_data;
      sp <= sp + 4'h1;
    end else if (pop_req) begin
      sp <= sp - 4'h1;
    end
  end
endmodule

// ---- test/isq_sequencer_tb.sv ----
`timescale 1ns/1ps
module isq_sequencer_tb;
  import isq_pkg::*;
  // ==========
  // signals
  logic sys_clk, rst, awvalid, awready, wvalid, wready, bvalid, bready, arvalid, arready, rvalid, rready;
  logic ext_req_n, clock_lost, t1_wrap, t1_ch0_event, t1_ch1_event, t2_wrap, t2_ch0_event, t2_ch1_event;
  logic keypad_flag, conversion_done_flag, conversion_irq_enable, tick_rollover_flag, tick_irq_enable;
  logic instr_done, swi_instr, rti_instr, fetch_valid, cpu_hold, push_valid, pop_req, set_imask;
  logic vector_valid, resume_valid;
  logic [1:0] bresp, rresp, r;
  logic [2:0] spi_irq_en;
  logic [3:0] wstrb, spi_flag;
  logic [7:0] awaddr, araddr, cpu_x_lo, cpu_acc, cpu_ccr, sci_flag, sci_irq_en, pop_data, push_data;
  logic [7:0] resume_x_lo, resume_acc, resume_ccr;
  logic [15:0] cpu_pc, fetch_addr, vector_addr, resume_pc, exq[$];
  logic [31:0] wdata, rdata, d;
  int errors = 0, n_tests = 0, seed = 30474;
  isq_sequencer dut (.*);
  isq_cpu_model stack (.*);
  initial begin
    sys_clk = 1'b0;
    forever #2.5 sys_clk = ~sys_clk;
  end
  task automatic chk(input string nm, input logic [31:0] e, s);
    n_tests++;
    if (e !== s) begin
      errors++;
      $display("MISMATCH %s expected %h seen %h", nm, e, s);
    end
  endtask
  task automatic final_report;
    $display("errors %0d n_tests %0d", errors, n_tests);
    if (errors == 0 && n_tests > 0) $display("verification passed");
    else $display("verification failed");
    $finish;
  endtask
  task automatic axw(input logic [7:0] a, input logic [31:0] v);
    @(posedge sys_clk);
    {awaddr, wdata, wstrb, awvalid, wvalid, bready} <= {a, v, 4'hf, 3'h7};
    do begin
      @(posedge sys_clk);
      if (awready) awvalid <= 1'b0;
      if (wready) wvalid <= 1'b0;
    end while (!bvalid);
    r = bresp;
    bready <= 1'b0;
  endtask
  task automatic axr(input logic [7:0] a);
    @(posedge sys_clk);
    {araddr, arvalid, rready} <= {a, 2'h3};
    do begin
      @(posedge sys_clk);
      if (arready) arvalid <= 1'b0;
    end while (!rvalid);
    {d, r} = {rdata, rresp};
    rready <= 1'b0;
  endtask
  // stacked bytes then vector, in the order the core sees them
  task automatic ent(input logic [15:0] p, v);
    exq = {exq, 16'(p[7:0]), 16'(p[15:8]), 16'(cpu_x_lo), 16'(cpu_acc), 16'(cpu_ccr), v};
  endtask
  task automatic bnd(input logic sw, rt, e, input logic [15:0] adj, v);
    @(posedge sys_clk);
    if (e) ent(cpu_pc - adj, v);
    {instr_done, swi_instr, rti_instr} <= {1'b1, sw, rt};
    @(posedge sys_clk);
    {instr_done, swi_instr, rti_instr} <= 3'h0;
    repeat (14) @(posedge sys_clk);
  endtask
  always @(posedge sys_clk) begin
    if (push_valid === 1'b1 || vector_valid === 1'b1 || resume_valid === 1'b1) begin
      chk("hold", 1, cpu_hold);
      if (vector_valid === 1'b1) chk("imask", 1, set_imask);
      if (exq.size() == 0) chk("stray step", 0, 1);
      else chk("step", exq.pop_front(), push_valid ? push_data : vector_valid ? vector_addr : resume_pc);
    end
  end
  initial begin
    repeat (4000) @(posedge sys_clk);
    errors++;
    final_report();
  end
  initial begin
    {rst, ext_req_n, awvalid, wvalid, bready, arvalid, rready, clock_lost, t1_wrap, t1_ch0_event} = 10'h300;
    {t1_ch1_event, t2_wrap, t2_ch0_event, t2_ch1_event, keypad_flag, conversion_done_flag} = '0;
    {conversion_irq_enable, tick_rollover_flag, tick_irq_enable, instr_done, swi_instr} = '0;
    {rti_instr, fetch_valid, awaddr, araddr, wdata, wstrb, spi_flag, spi_irq_en, sci_flag} = '0;
    {sci_irq_en, fetch_addr, cpu_pc, cpu_x_lo, cpu_acc, cpu_ccr} = '0;
    repeat (2) @(posedge sys_clk);
    rst <= 1'b0;
    axr(ISQ_A_CTRL);
    chk("ctrl", 32'h201, d);
    axr(8'h14);
    chk("resp", 32'(ISQ_RESP_SLVERR), 32'(r));
    axw(ISQ_A_CTRL, 32'h8);
    chk("bresp", 32'(ISQ_RESP_OKAY), 32'(r));
    axw(ISQ_A_PEND, 32'hffffffff);
    chk("ro bresp", 32'(ISQ_RESP_SLVERR), 32'(r));
    {ext_req_n, t1_ch0_event} <= 2'h1;
    @(posedge sys_clk);
    {ext_req_n, t1_ch0_event} <= 2'h2;
    axr(ISQ_A_PEND);
    chk("pend", 32'ha, d);
    cpu_ccr <= 8'h08;
    bnd(0, 0, 0, 0, 0);
    {cpu_pc, cpu_x_lo, cpu_acc, cpu_ccr} <= {16'($random(seed)), 16'($random(seed)), 8'h00};
    bnd(0, 0, 1, 1, 16'hfffa);
    axw(ISQ_A_FLAGS, 32'h1);
    bnd(0, 0, 1, 1, 16'hfff6);
    // the unmasked timer request is still there when the return ends
    exq.push_back(cpu_pc - 16'h1);
    ent(cpu_pc - 16'h1, 16'hfff6);
    bnd(0, 1, 0, 0, 0);
    chk("resume", {8'h00, cpu_x_lo, cpu_acc, cpu_ccr}, {8'h00, resume_x_lo, resume_acc, resume_ccr});
    axw(ISQ_A_FLAGS, 32'h4);
    {cpu_pc, cpu_ccr} <= {16'($random(seed)), 8'h08};
    bnd(1, 0, 1, 0, ISQ_VEC_SWI);
    axw(ISQ_A_BRK, 32'h00011234);
    // timer events, break fetch and random serial levels in one cycle
    {fetch_addr, fetch_valid, t1_wrap, t2_ch0_event} <= {16'h1234, 3'h7};
    {spi_flag, spi_irq_en} <= 7'($random(seed));
    @(posedge sys_clk);
    {fetch_valid, t1_wrap, t2_ch0_event} <= 3'h0;
    axr(ISQ_A_PEND);
    chk("spi pend", {21'h000000, spi_flag[3] & spi_irq_en[2], (spi_flag[0] & spi_irq_en[0])
      | ((spi_flag[1] | spi_flag[2]) & spi_irq_en[1]), 9'h0}, d);
    bnd(0, 0, 1, 0, ISQ_VEC_SWI);
    chk("left", 0, 32'(exq.size()));
    final_report();
  end
endmodule
